// file: design/cwc_pkg.sv
// Package of the CAN transceiver wake and fault control block.
// Assumes one 200 MHz clock; all times become cycle counts here.
`default_nettype none
package cwc_pkg;
  // Register indices on the plain register port
  localparam logic [7:0] REG_CTRL4 = 8'h04;
  localparam logic [7:0] REG_CFG_FIRST = 8'h07;
  localparam logic [7:0] REG_CFG_LAST = 8'h0f;
  localparam logic [7:0] REG_CTRL16 = 8'h10;
  localparam logic [7:0] REG_STAT4 = 8'h14;
  localparam logic [7:0] REG_FAULT = 8'h15;
  localparam int CFG_COUNT = 9;
  // Field positions
  localparam int CTRL4_ACT = 0;
  localparam int CTRL4_RXONLY = 1;
  localparam int CTRL4_LOOP = 2;
  localparam int CTRL16_SWEN = 0;
  localparam int ST4_SYSERR = 9;
  localparam int ST4_OSCFAIL = 10;
  localparam int ST4_WUP = 11;
  localparam int ST4_WUF = 12;
  localparam int ST4_FRAME_DETECT_ERROR = 13;
  localparam int FLT_TXDOM = 0;
  localparam int FLT_BUSREC = 1;
  localparam int FLT_BUSDOM = 2;
  localparam int FLT_RXDREC = 3;
  // Reset values
  localparam logic [2:0] CTRL4_RESET = 3'h0;
  localparam logic SWEN_RESET = 1'b0;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int TXDOM_TIMEOUT_NS = 2000000;
  localparam int BUSDOM_TIMEOUT_NS = 2000000;
  localparam int WAKE_FILTER_NS = 1000;
  localparam int WAKE_WINDOW_NS = 1000000;
  localparam int SILENCE_NS = 1000000;
  localparam int OSC_WINDOW_NS = 300000;
  localparam int FOLLOW_NS = 1000;
  localparam int BIT_NS = 1000;
  localparam int IRQ_NS = 1000;
  localparam int TXDOM_CYC = (TXDOM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSDOM_CYC = (BUSDOM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILTER_CYC = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WINDOW_CYC = WAKE_WINDOW_NS / CLK_PERIOD_NS;
  localparam int SILENCE_CYC = (SILENCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_CYC = OSC_WINDOW_NS / CLK_PERIOD_NS;
  localparam int FOLLOW_CYC = FOLLOW_NS / CLK_PERIOD_NS;
  localparam int BIT_CYC = (BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IRQ_CYC = (IRQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FAIL_LIMIT = 4;
  localparam int OSC_MIN_BITS = 6;
  localparam int FEC_LIMIT = 32;

  typedef enum logic [1:0] {
    CWC_NORMAL = 2'b00,
    CWC_STANDBY = 2'b01,
    CWC_SLEEP = 2'b10,
    CWC_FDSLEEP = 2'b11
  } cwc_state_t;

  typedef struct packed {
    logic loopbackEnable;
    logic receiveOnly;
    logic transceiverActivate;
  } cwc_ctrl_t;

  typedef struct packed {
    logic rxdRecessive;
    logic busDominant;
    logic busRecessive;
    logic txDominant;
  } cwc_fault_t;
endpackage : cwc_pkg
`default_nettype wire

// file: design/cwc_wake_control.sv
// Wake, mode and fault control of a high-speed CAN transceiver.
// Bus and pin levels are synchronous to clk_sys; low means dominant.
// Frame decoding lives outside: it reports matching and faulty frames as pulses.
//
// The implementer's own choices: the register offsets and strobed register access.
`default_nettype none

module cwc_wake_control
  import cwc_pkg::*;
#(
  parameter int TxDomCycles = TXDOM_CYC,
  parameter int BusDomCycles = BUSDOM_CYC,
  parameter int WindowCycles = WINDOW_CYC,
  parameter int SilenceCycles = SILENCE_CYC,
  parameter int OscCycles = OSC_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  input wire logic canTxInput,
  input wire logic busLevel,
  input wire logic rxPinLevel,
  input wire logic systemErrorIn,
  input wire logic thermalShutdown1,
  input wire logic wakeFrameMatch,
  input wire logic frameErrorPulse,
  output logic canRxOutput,
  output logic canTxDrive,
  output logic txEnable,
  output logic rxEnable,
  output logic terminationEnable,
  output logic frameDetectEnable,
  output logic hostWakeup,
  output logic [1:0] trxState
);

  ////////////////////////////////////////////////////////////////////////////
  // Register access
  cwc_ctrl_t ctrl_q;
  logic swEn_q;
  logic [CFG_COUNT-1:0] cfgRead_q;
  logic [15:0] cfgReg_q [CFG_COUNT];
  cwc_fault_t fault_q;
  cwc_fault_t faultSet;
  logic sysErr_q;
  logic oscFail_q;
  logic wupFlag_q;
  logic wufFlag_q;
  logic frame_detect_error_q;
  logic fecExpire;
  logic wupDetect;
  logic oscFailSet;
  cwc_state_t state_q;
  logic [15:0] rdMux;

  wire logic isCfg = (regAddr >= REG_CFG_FIRST) && (regAddr <= REG_CFG_LAST);
  wire logic [3:0] cfgIdx = 4'(regAddr - REG_CFG_FIRST);
  wire logic wrCtrl4 = regWrite && (regAddr == REG_CTRL4);
  wire logic wrCtrl16 = regWrite && (regAddr == REG_CTRL16);
  wire logic wrStat4 = regWrite && (regAddr == REG_STAT4);
  wire logic wrFault = regWrite && (regAddr == REG_FAULT);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= CTRL4_RESET;
    end else if (wrCtrl4) begin
      ctrl_q <= cwc_ctrl_t'(regWrData[CTRL4_LOOP:CTRL4_ACT]);
    end
  end

  generate
    for (genvar i = 0; i < CFG_COUNT; i++) begin : g_cfg
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          cfgReg_q[i] <= CFG_RESET;
          cfgRead_q[i] <= 1'b0;
        end else begin
          if (regWrite && isCfg && cfgIdx == 4'(i)) begin
            cfgReg_q[i] <= regWrData;
          end
          if (regWrite) begin
            cfgRead_q[i] <= 1'b0;
          end else if (regRead && isCfg && cfgIdx == 4'(i)) begin
            cfgRead_q[i] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Flags are judged before this very write clears them
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      swEn_q <= SWEN_RESET;
    end else if (sysErr_q || fecExpire) begin
      swEn_q <= 1'b0;
    end else if (wrCtrl16) begin
      swEn_q <= regWrData[CTRL16_SWEN] && (&cfgRead_q);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sysErr_q <= 1'b0;
    end else begin
      sysErr_q <= systemErrorIn;
    end
  end

  // Sticky flags: a set in the same cycle as a write-one clear wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_q <= '0;
    end else begin
      fault_q <= (wrFault ? (fault_q & ~cwc_fault_t'(regWrData[3:0])) : fault_q) | faultSet;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      oscFail_q <= 1'b0;
      wupFlag_q <= 1'b0;
      wufFlag_q <= 1'b0;
      frame_detect_error_q <= 1'b0;
    end else begin
      oscFail_q <= (oscFail_q && !(wrStat4 && regWrData[ST4_OSCFAIL])) || oscFailSet;
      wupFlag_q <= (wupFlag_q && !(wrStat4 && regWrData[ST4_WUP])) || wupDetect;
      wufFlag_q <= (wufFlag_q && !(wrStat4 && regWrData[ST4_WUF])) || wakeFrameMatch &&
                   frameDetectEnable;
      frame_detect_error_q <= (frame_detect_error_q && !(wrStat4 && regWrData[ST4_FRAME_DETECT_ERROR])) || fecExpire;
    end
  end

  always_comb begin
    rdMux = 16'h0000;
    if (isCfg) begin
      rdMux = cfgReg_q[cfgIdx];
    end else begin
      case (regAddr)
        REG_CTRL4: rdMux = {13'h0000, ctrl_q};
        REG_CTRL16: rdMux = {15'h0000, swEn_q};
        REG_STAT4: rdMux = {2'h0, frame_detect_error_q, wufFlag_q, wupFlag_q, oscFail_q, sysErr_q,
                            cfgRead_q};
        REG_FAULT: rdMux = {12'h000, fault_q};
        default: rdMux = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regRdData <= 16'h0000;
    end else begin
      regRdData <= regRead ? rdMux : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit fault monitors
  logic txPrev_q;
  logic [31:0] txDomCnt_q;
  logic [31:0] busDomCnt_q;
  logic [7:0] followCnt_q;
  logic followArmed_q;
  logic [2:0] busFail_q;
  logic [2:0] rxdFail_q;
  logic busSeen_q;
  logic rxdSeen_q;

  wire logic txFall = txPrev_q && !canTxInput;
  wire logic followDone = followArmed_q && (followCnt_q == 8'(FOLLOW_CYC));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txPrev_q <= 1'b1;
      txDomCnt_q <= '0;
      busDomCnt_q <= '0;
    end else begin
      txPrev_q <= canTxInput;
      txDomCnt_q <= canTxInput ? '0 : (txDomCnt_q == 32'(TxDomCycles) ? txDomCnt_q :
                    txDomCnt_q + 32'd1);
      busDomCnt_q <= busLevel ? '0 : (busDomCnt_q == 32'(BusDomCycles) ? busDomCnt_q :
                     busDomCnt_q + 32'd1);
    end
  end

  // Each dominant transmit edge while txEnable is set opens a window in which bus and pin must follow
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      followArmed_q <= 1'b0;
      followCnt_q <= '0;
      busSeen_q <= 1'b0;
      rxdSeen_q <= 1'b0;
      busFail_q <= '0;
      rxdFail_q <= '0;
    end else begin
      if (txFall && txEnable) begin
        followArmed_q <= 1'b1;
        followCnt_q <= '0;
        busSeen_q <= 1'b0;
        rxdSeen_q <= 1'b0;
      end else if (followArmed_q) begin
        followCnt_q <= followCnt_q + 8'd1;
        busSeen_q <= busSeen_q || !busLevel;
        rxdSeen_q <= rxdSeen_q || !rxPinLevel;
        if (followDone) begin
          followArmed_q <= 1'b0;
          busFail_q <= busSeen_q ? '0 : (busFail_q == 3'(FAIL_LIMIT) ? busFail_q :
                       busFail_q + 3'd1);
          rxdFail_q <= rxdSeen_q ? '0 : (rxdFail_q == 3'(FAIL_LIMIT) ? rxdFail_q :
                       rxdFail_q + 3'd1);
        end
      end
      if (wrFault) begin
        busFail_q <= '0;
        rxdFail_q <= '0;
      end
    end
  end

  always_comb begin
    faultSet.txDominant = txDomCnt_q == 32'(TxDomCycles);
    faultSet.busDominant = busDomCnt_q == 32'(BusDomCycles);
    // Pulse on the miss that reaches the limit, so a clear is not undone by a stale count
    faultSet.busRecessive = followDone && !busSeen_q &&
                            busFail_q == 3'(FAIL_LIMIT - 1);
    faultSet.rxdRecessive = followDone && !rxdSeen_q &&
                            rxdFail_q == 3'(FAIL_LIMIT - 1);
  end

  // Permanent bus dominant only reports; it never gates the driver
  always_comb begin
    txEnable = (state_q == CWC_NORMAL) && !ctrl_q.receiveOnly && !fault_q.txDominant &&
               !fault_q.busRecessive && !fault_q.rxdRecessive &&
               !thermalShutdown1;
    rxEnable = 1'b1;
    terminationEnable = 1'b1;
    canTxDrive = txEnable && !canTxInput;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pattern wake detector
  typedef enum logic [1:0] {
    PAT_IDLE = 2'b00,
    PAT_PULSE1 = 2'b01,
    PAT_GAP = 2'b10,
    PAT_PULSE2 = 2'b11
  } cwc_pat_t;
  cwc_pat_t pat_q;
  logic [15:0] patLen_q;
  logic [31:0] patWin_q;
  logic patEnable;

  assign patEnable = (state_q == CWC_SLEEP) ||
                     (state_q == CWC_STANDBY && (!swEn_q || oscFail_q));
  assign wupDetect = patEnable && pat_q == PAT_PULSE2 && !busLevel &&
                     patLen_q == 16'(FILTER_CYC);

  always_ff @(posedge clk_sys) begin
    if (rst || !patEnable) begin
      pat_q <= PAT_IDLE;
      patLen_q <= '0;
      patWin_q <= '0;
    end else begin
      patWin_q <= (pat_q == PAT_IDLE) ? '0 : patWin_q + 32'd1;
      if (pat_q != PAT_IDLE && patWin_q >= 32'(WindowCycles)) begin
        pat_q <= PAT_IDLE;
        patLen_q <= '0;
      end else begin
        case (pat_q)
          PAT_IDLE: begin
            if (!busLevel) begin
              pat_q <= PAT_PULSE1;
              patLen_q <= 16'd1;
            end
          end
          PAT_PULSE1: begin
            if (!busLevel) begin
              patLen_q <= patLen_q + 16'd1;
            end else if (patLen_q > 16'(FILTER_CYC)) begin
              pat_q <= PAT_GAP;
              patLen_q <= 16'd1;
            end else begin
              pat_q <= PAT_IDLE;
              patLen_q <= '0;
            end
          end
          PAT_GAP: begin
            if (busLevel) begin
              patLen_q <= patLen_q + 16'd1;
            end else if (patLen_q > 16'(FILTER_CYC)) begin
              pat_q <= PAT_PULSE2;
              patLen_q <= 16'd1;
            end else begin
              pat_q <= PAT_IDLE;
              patLen_q <= '0;
            end
          end
          PAT_PULSE2: begin
            if (!busLevel && !wupDetect) begin
              patLen_q <= patLen_q + 16'd1;
            end else begin
              pat_q <= PAT_IDLE;
              patLen_q <= '0;
            end
          end
          default: pat_q <= PAT_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame detection support: silence, frame errors, oscillator check
  logic [31:0] silence_q;
  logic [5:0] fec_q;
  logic [31:0] oscTimer_q;
  logic [15:0] bitCyc_q;
  logic [2:0] recBits_q;
  logic busPrev_q;

  wire logic silenceHit = silence_q == 32'(SilenceCycles);
  // Matching itself, incl. RTR ignored and full DLC compare, is in the frame decoder
  assign frameDetectEnable = swEn_q && !oscFail_q &&
                             (state_q == CWC_STANDBY || state_q == CWC_FDSLEEP);
  assign fecExpire = frameDetectEnable && frameErrorPulse && fec_q == 6'(FEC_LIMIT - 1);

  always_ff @(posedge clk_sys) begin
    if (rst || !busLevel || silenceHit) begin
      silence_q <= '0;
    end else begin
      silence_q <= silence_q + 32'd1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !frameDetectEnable || fecExpire) begin
      fec_q <= '0;
    end else if (silenceHit) begin
      fec_q <= '0;
    end else if (frameErrorPulse) begin
      fec_q <= fec_q + 6'd1;
    end
  end

  // Timer starts on a recessive-to-dominant edge when idle, counts recessive bits
  assign oscFailSet = swEn_q && oscTimer_q == 32'd1 && recBits_q < 3'(OSC_MIN_BITS);
  always_ff @(posedge clk_sys) begin
    if (rst || !swEn_q) begin
      busPrev_q <= 1'b1;
      oscTimer_q <= '0;
      bitCyc_q <= '0;
      recBits_q <= '0;
    end else begin
      busPrev_q <= busLevel;
      if (oscTimer_q == '0) begin
        if (busPrev_q && !busLevel) begin
          oscTimer_q <= 32'(OscCycles);
          bitCyc_q <= '0;
          recBits_q <= '0;
        end
      end else begin
        oscTimer_q <= oscTimer_q - 32'd1;
        if (busLevel) begin
          if (bitCyc_q == 16'(BIT_CYC - 1)) begin
            bitCyc_q <= '0;
            if (recBits_q != 3'(OSC_MIN_BITS)) begin
              recBits_q <= recBits_q + 3'd1;
            end
          end else begin
            bitCyc_q <= bitCyc_q + 16'd1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transceiver state and host wake
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= CWC_STANDBY;
    end else begin
      case (state_q)
        CWC_NORMAL: begin
          if (!ctrl_q.transceiverActivate) begin
            state_q <= CWC_STANDBY;
          end
        end
        CWC_STANDBY: begin
          if (ctrl_q.transceiverActivate) begin
            state_q <= CWC_NORMAL;
          end else if (frameDetectEnable && silenceHit) begin
            state_q <= CWC_SLEEP;
          end
        end
        CWC_SLEEP: begin
          if (ctrl_q.transceiverActivate) begin
            state_q <= CWC_NORMAL;
          end else if (!swEn_q) begin
            state_q <= CWC_STANDBY;
          end else if (wupDetect) begin
            state_q <= CWC_FDSLEEP;
          end
        end
        CWC_FDSLEEP: begin
          if (ctrl_q.transceiverActivate) begin
            state_q <= CWC_NORMAL;
          end else if (wakeFrameMatch || fecExpire || !frameDetectEnable) begin
            state_q <= CWC_STANDBY;
          end else if (silenceHit) begin
            state_q <= CWC_SLEEP;
          end
        end
        default: state_q <= CWC_STANDBY;
      endcase
    end
  end

  // Interrupt is a low pulse on the receive output of fixed length
  logic [15:0] irqCnt_q;
  logic hostWake_q;
  wire logic irqEvent = (state_q == CWC_STANDBY && ((wupDetect && !swEn_q) ||
                         (wakeFrameMatch && frameDetectEnable))) || fecExpire;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqCnt_q <= '0;
      hostWake_q <= 1'b0;
    end else begin
      irqCnt_q <= irqEvent ? 16'(IRQ_CYC) : (irqCnt_q != '0 ? irqCnt_q - 16'd1 : irqCnt_q);
      hostWake_q <= (state_q == CWC_FDSLEEP && wakeFrameMatch) || fecExpire ||
                    (state_q == CWC_STANDBY && wupDetect);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      canRxOutput <= 1'b1;
    end else if (ctrl_q.loopbackEnable) begin
      canRxOutput <= canTxInput;
    end else if (state_q == CWC_NORMAL) begin
      canRxOutput <= busLevel;
    end else begin
      canRxOutput <= !(irqEvent || irqCnt_q > 16'd1);
    end
  end

  assign hostWakeup = hostWake_q;
  assign trxState = state_q;

endmodule // cwc_wake_control
`default_nettype wire

// file: bench/cwc_wake_control_chk.sv
// Port checker of the CAN wake and fault control block.
// Bound to cwc_wake_control; sees its ports only.
`default_nettype none
module cwc_wake_control_chk
  import cwc_pkg::*;
#(
  parameter int TxDomCycles = TXDOM_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic regRead,
  input wire logic [15:0] regRdData,
  input wire logic canTxInput,
  input wire logic thermalShutdown1,
  input wire logic wakeFrameMatch,
  input wire logic canTxDrive,
  input wire logic txEnable,
  input wire logic rxEnable,
  input wire logic terminationEnable,
  input wire logic frameDetectEnable,
  input wire logic hostWakeup,
  input wire logic [1:0] trxState
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  int lowCnt_q;
  // Saturates so a stuck input cannot wrap the count
  always_ff @(posedge clk_sys) begin
    if (rst || canTxInput) begin
      lowCnt_q <= 0;
    end else if (lowCnt_q < 1000000) begin
      lowCnt_q <= lowCnt_q + 1;
    end
  end
  ////////////////////////////////////////
  sequence s_frame_fd;
    wakeFrameMatch && trxState == CWC_FDSLEEP;
  endsequence
  sequence s_up;
    ##[1:2] hostWakeup;
  endsequence
  property p_rx_on; rxEnable && terminationEnable; endproperty
  a_rx_on: assert property (p_rx_on) else $error("receiver off");
  property p_drive; canTxDrive == (txEnable && !canTxInput); endproperty
  a_drive: assert property (p_drive) else $error("driver not gated");
  property p_therm; thermalShutdown1 |-> !txEnable; endproperty
  a_therm: assert property (p_therm) else $error("hot transmitter");
  property p_txdom; lowCnt_q >= TxDomCycles + 3 |-> !txEnable; endproperty
  a_txdom: assert property (p_txdom) else $error("tx timeout missed");
  property p_rd_idle; !regRead |=> regRdData == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_pulse; hostWakeup |=> !hostWakeup; endproperty
  a_pulse: assert property (p_pulse) else $error("wake pulse long");
  property p_fd_wake; s_frame_fd |-> s_up; endproperty
  a_fd_wake: assert property (p_fd_wake) else $error("host not woken");
  property p_fd_state; s_frame_fd |-> ##[1:2] trxState == CWC_STANDBY; endproperty
  a_fd_state: assert property (p_fd_state) else $error("no standby");
  property p_sleep_fd; trxState == CWC_SLEEP |-> !frameDetectEnable; endproperty
  a_sleep_fd: assert property (p_sleep_fd) else $error("detect in sleep");
  property p_stby_tx; trxState != CWC_NORMAL |-> !txEnable; endproperty
  a_stby_tx: assert property (p_stby_tx) else $error("transmitter on outside normal");
endmodule // cwc_wake_control_chk

bind cwc_wake_control cwc_wake_control_chk #(.TxDomCycles(TxDomCycles)) u_chk (
  .clk_sys, .rst, .regRead, .regRdData, .canTxInput, .thermalShutdown1,
  .wakeFrameMatch, .canTxDrive, .txEnable, .rxEnable, .terminationEnable,
  .frameDetectEnable, .hostWakeup, .trxState
);
`default_nettype wire

// file: bench/cwc_bus_model.sv
// Behavioural CAN bus and receive pin facing the transceiver.
// The bench steers faults; levels follow the driver one clock later.
`default_nettype none
module cwc_bus_model (
  input wire logic clk_sys,
  input wire logic canTxDrive,
  input wire logic forceDom,
  input wire logic stuckBus,
  input wire logic stuckRx,
  output var logic busLevel,
  output var logic rxPinLevel
);
  logic dom;
  // Bias network pulls the bus recessive whenever nobody drives it
  assign dom = (canTxDrive && !stuckBus) || forceDom;
  initial busLevel = 1'b1;
  initial rxPinLevel = 1'b1;
  always @(posedge clk_sys) begin
    busLevel <= !dom;
    rxPinLevel <= stuckRx || !dom;
  end
endmodule // cwc_bus_model
`default_nettype wire

// file: bench/cwc_wake_control_tb.sv
// Self-checking bench of the CAN wake and fault control block.
// Assumes package, design, bus model and checker compiled before it.
`default_nettype none
module cwc_wake_control_tb
  import cwc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TXD = 300;
  localparam int BSD = 300;
  localparam int SIL = 500;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic canTxInput = 1'b1;
  logic systemErrorIn = 1'b0;
  logic thermalShutdown1 = 1'b0;
  logic wakeFrameMatch = 1'b0;
  logic frameErrorPulse = 1'b0;
  logic forceDom = 1'b0;
  logic stuckBus = 1'b0;
  logic stuckRx = 1'b0;
  logic [15:0] regRdData;
  logic busLevel, rxPinLevel, canRxOutput, canTxDrive, txEnable, rxEnable;
  logic terminationEnable, frameDetectEnable, hostWakeup;
  logic [1:0] trxState;
  int mismatches = 0;
  int comparisons = 0;
  always #2.5 clk_sys = ~clk_sys;
  cwc_wake_control #(.TxDomCycles(TXD), .BusDomCycles(BSD), .WindowCycles(2000),
    .SilenceCycles(SIL), .OscCycles(1500)) u_cwc_wake_control (
    .clk_sys, .rst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .canTxInput, .busLevel, .rxPinLevel, .systemErrorIn, .thermalShutdown1,
    .wakeFrameMatch, .frameErrorPulse, .canRxOutput, .canTxDrive, .txEnable,
    .rxEnable, .terminationEnable, .frameDetectEnable, .hostWakeup, .trxState);
  cwc_bus_model u_cwc_bus_model (.clk_sys, .canTxDrive, .forceDom, .stuckBus,
    .stuckRx, .busLevel, .rxPinLevel);
  ////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  // Ends on an edge so callers may drive straight after
  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(negedge clk_sys);
    chk("regRdData", e, regRdData & m);
    @(posedge clk_sys);
  endtask
  task automatic rd_cfg();
    for (int a = REG_CFG_FIRST; a <= REG_CFG_LAST; a++) rd(8'(a), 16'hffff, CFG_RESET);
  endtask
  task automatic pulse_frame();
    wakeFrameMatch <= 1'b1;
    cyc(1);
    wakeFrameMatch <= 1'b0;
    cyc(2);
  endtask
  // Two dominant pulses of w cycles with a w-cycle gap
  task automatic pat(input int w);
    cyc(1);
    forceDom <= 1'b1;
    cyc(w);
    forceDom <= 1'b0;
    cyc(w);
    forceDom <= 1'b1;
    cyc(w);
    forceDom <= 1'b0;
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    #1 chk("trxState", 16'(CWC_STANDBY), 16'(trxState));
    chk("txEnable", 16'h0, 16'(txEnable));
    rd(REG_CTRL16, 16'hffff, 16'h0000);
    rd(REG_CTRL4, 16'hffff, 16'h0000);
    wr(8'h3f, 16'hffff);
    rd(8'h3f, 16'hffff, 16'h0000);
  endtask
  task automatic t_swen();
    wr(REG_CTRL16, 16'h0001);
    rd(REG_CTRL16, 16'hffff, 16'h0000);
    rd_cfg();
    rd(REG_STAT4, 16'h01ff, 16'h01ff);
    wr(REG_CFG_FIRST, CFG_RESET);
    rd(REG_STAT4, 16'h01ff, 16'h0000);
    rd_cfg();
    systemErrorIn <= 1'b1;
    wr(REG_CTRL16, 16'h0001);
    rd(REG_CTRL16, 16'hffff, 16'h0000);
    rd(REG_STAT4, 16'h0200, 16'h0200);
    systemErrorIn <= 1'b0;
    rd_cfg();
    wr(REG_CTRL16, 16'h0001);
    rd(REG_CTRL16, 16'hffff, 16'h0001);
    systemErrorIn <= 1'b1;
    cyc(3);
    rd(REG_CTRL16, 16'hffff, 16'h0000);
    systemErrorIn <= 1'b0;
  endtask
  task automatic t_sleep();
    rd_cfg();
    wr(REG_CTRL16, 16'h0001);
    cyc(SIL + 20);
    #1 chk("trxState", 16'(CWC_SLEEP), 16'(trxState));
    pat(220);
    cyc(2);
    #1 chk("trxState", 16'(CWC_FDSLEEP), 16'(trxState));
    cyc(1);
    pulse_frame();
    #1 chk("trxState", 16'(CWC_STANDBY), 16'(trxState));
    rd(REG_STAT4, 16'h1800, 16'h1800);
    pulse_frame();
    #1 chk("canRxOutput", 16'h0, 16'(canRxOutput));
    chk("trxState", 16'(CWC_STANDBY), 16'(trxState));
    cyc(1);
    repeat (FEC_LIMIT) begin
      frameErrorPulse <= 1'b1;
      cyc(1);
      frameErrorPulse <= 1'b0;
      cyc(1);
    end
    rd(REG_CTRL16, 16'hffff, 16'h0000);
    rd(REG_STAT4, 16'h2000, 16'h2000);
    wr(REG_STAT4, 16'h3c00);
  endtask
  task automatic t_pattern();
    pat(150);
    cyc(300);
    #1 chk("canRxOutput", 16'h1, 16'(canRxOutput));
    pat(220);
    cyc(1);
    #1 chk("canRxOutput", 16'h0, 16'(canRxOutput));
    rd(REG_STAT4, 16'h0800, 16'h0800);
    wr(REG_STAT4, 16'h3c00);
  endtask
  task automatic t_active();
    wr(REG_CTRL4, 16'h0001);
    cyc(2);
    #1 chk("trxState", 16'(CWC_NORMAL), 16'(trxState));
    chk("txEnable", 16'h1, 16'(txEnable));
    wr(REG_CTRL4, 16'h0003);
    #1 chk("txEnable", 16'h0, 16'(txEnable));
    wr(REG_CTRL4, 16'h0007);
    canTxInput <= 1'b0;
    cyc(3);
    #1 chk("canRxOutput", 16'h0, 16'(canRxOutput));
    cyc(1);
    canTxInput <= 1'b1;
    wr(REG_CTRL4, 16'h0001);
    thermalShutdown1 <= 1'b1;
    cyc(2);
    #1 chk("txEnable", 16'h0, 16'(txEnable));
    cyc(1);
    thermalShutdown1 <= 1'b0;
  endtask
  // Fault k: 0 tx timeout, 1 bus stuck, 2 bus dominant, 3 receive pin stuck
  task automatic t_fault(input int k);
    stuckBus <= (k == 1);
    stuckRx <= (k == 3);
    forceDom <= (k == 2);
    canTxInput <= (k != 0);
    cyc(k[0] ? 1 : TXD + 20);
    repeat (k[0] ? FAIL_LIMIT : 0) begin
      canTxInput <= 1'b0;
      cyc(250);
      canTxInput <= 1'b1;
      cyc(20);
    end
    {stuckBus, stuckRx, forceDom, canTxInput} <= 4'h1;
    cyc(3);
    rd(REG_FAULT, 16'(1 << k), 16'(1 << k));
    #1 chk("txEnable", 16'(k == 2), 16'(txEnable));
    wr(REG_FAULT, 16'h000f);
    cyc(2);
    #1 chk("txEnable", 16'h1, 16'(txEnable));
    cyc(1);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    cyc(30000);
    mismatches++;
    complete_run();
  end
  initial begin
    cyc(3);
    rst <= 1'b0;
    t_reset();
    t_swen();
    t_sleep();
    t_pattern();
    t_active();
    t_fault(0);
    t_fault(1);
    t_fault(2);
    t_fault(3);
    complete_run();
  end
endmodule // cwc_wake_control_tb
`default_nettype wire
